// ---- hw/cef_consts.svh ----
`ifndef CEF_CONSTS_SVH
`define CEF_CONSTS_SVH

// ----------------------------------------
// register word indices (byte address = index * 4)
// ----------------------------------------
`define CEF_ADDR_W      12
`define CEF_IDX_ERRCNT  10'h000
`define CEF_IDX_FSTAT   10'h001
`define CEF_IDX_MASK0   10'h004
`define CEF_IDX_FCTL0   10'h008

// ----------------------------------------
// error state thresholds
// ----------------------------------------
`define CEF_LVL_BUSOFF  9'h100
`define CEF_LVL_PASSIVE 9'h080
`define CEF_LVL_WARN    9'h060
`define CEF_RLVL_PASSIVE 8'h80
`define CEF_RLVL_WARN   8'h60

// ----------------------------------------
// acceptance mask layout
// ----------------------------------------
`define CEF_MSK_STD_HI  31
`define CEF_MSK_STD_LO  21
`define CEF_MSK_TYPE    19
`define CEF_MSK_EXT_HI  17
`define CEF_MSK_EXT_LO  0
`define CEF_MSK_RW      32'hffeb_ffff
`define CEF_MSK_RST     32'h0000_0000

// ----------------------------------------
// filter control byte layout and mode codes
// ----------------------------------------
`define CEF_FLT_PER_REG 4
`define CEF_FLT_RST     8'h00
`define CEF_OPERATING_MODE_FIELD_CFG   3'h4

`endif

// ---- hw/cef_pkg.sv ----
package cef_pkg;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  // order matches bits 21..16 of the error count register
  typedef struct packed {
    logic tx_bus_off_flag;
    logic tx_passive_flag;
    logic rx_passive_flag;
    logic tx_warning_flag;
    logic rx_warning_flag;
    logic any_warning_flag;
  } cef_err_flags_t;

  // identifier of a received message or of a filter
  typedef struct packed {
    logic [10:0] std_id;
    logic        ext;
    logic [17:0] ext_id;
  } cef_ident_t;

  // one byte of filter control
  typedef struct packed {
    logic       filter_enable;
    logic [1:0] mask_select;
    logic [4:0] fifo_select;
  } cef_fltctl_t;

endpackage

// ---- hw/cef_top.sv ----
`timescale 1ns/1ps
`include "cef_consts.svh"

// ----------------------------------------
// block overview
// ----------------------------------------
// three independent parts share one register bus:
//   - error state flags derived from the engine's error counts
//   - per-fifo interrupt pending summary
//   - acceptance masks and filter control, plus the match logic
//
// byte address map (one aligned 32-bit word each):
//   0x00        error count and error state flags, read-only
//   0x04        fifo interrupt pending bits, read-only
//   0x10..0x1c  acceptance masks 0..3, read/write
//   0x20..0x3c  filter control words 0..7, four filters per word
//   anything else answers with pslverr and reads zero
//
// error count word layout:
//   bits 31..22 always zero
//   bits 21..16 bus-off, tx passive, rx passive, tx warn, rx warn, any warn
//   bits 15..8  low byte of the transmit count
//   bits 7..0   receive count
// the transmit count is nine bits wide so that bus-off can be seen at all;
// only its low byte fits the field, so software must use the flag
// rather than the field to spot bus-off
//
// acceptance mask word layout:
//   bits 31..21 standard identifier compare enables
//   bit  20     reserved, reads zero
//   bit  19     identifier type match enable
//   bit  18     reserved, reads zero
//   bits 17..0  extended identifier compare enables
//
// filter control byte layout, filter k in word k/4, byte k%4:
//   bit 7       filter enable
//   bits 6..5   mask select, picks acceptance mask 0..3
//   bits 4..0   fifo select, destination fifo 0..31
//
// bus timing:
//   read data and the decode error are latched in the setup cycle, so
//   pready is simply psel & penable and every transfer takes two cycles;
//   a write lands at the end of its access cycle and is visible to a
//   read whose setup cycle follows directly
//
// limitations a user must know:
//   - mask writes outside configuration mode are silently dropped, no
//     error is raised, so firmware must check the mode before writing
//   - select fields of an enabled filter ignore writes; the enable bit
//     in the same write is taken, but the old enable decides whether the
//     selects follow, so disabling and reprogramming needs two writes
//   - the error flags and counts lag the engine's counts by one cycle
//
// acceptance timing:
//   a message is taken on the edge where msg_valid is high; one cycle
//   later accept_valid pulses for one cycle if any enabled filter
//   matches, with fifo and filter number alongside; those two hold
//   until the next accepted message
//   when several filters match, the lowest-numbered one wins
//
// trade-off in the match logic:
//   all filters are compared in parallel in one cycle; this costs a wide
//   comparator per filter but keeps the result latency fixed at one cycle
//   regardless of how many filters are enabled
//
// type match behaviour:
//   type match set: the message format must equal the filter's extended
//     bit; a standard message needs only the standard bits to match, an
//     extended message needs both the standard and extended bits
//   type match clear: a standard-bit match alone accepts either format

module cef_top
  import cef_pkg::*;
#(
  parameter int NUM_FILT = 32,
  parameter int NUM_MASK = 4,
  parameter int NUM_FIFO = 32,
  parameter int IRQ_SRC  = 4
) (
  // clock and reset
  input  wire logic                               core_clk,
  input  wire logic                               rst,
  // apb slave
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [`CEF_ADDR_W-1:0]             paddr,
  input  wire logic [31:0]                        pwdata,
  input  wire logic [3:0]                         pstrb,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  // protocol engine state
  input  wire logic [8:0]                         tx_error_count,
  input  wire logic [7:0]                         rx_error_count,
  input  wire logic [2:0]                         operating_mode_field,
  // fifo interrupt sources and their enables
  input  wire logic [NUM_FIFO-1:0][IRQ_SRC-1:0]   fifo_irq_src,
  input  wire logic [NUM_FIFO-1:0][IRQ_SRC-1:0]   fifo_irq_en,
  // filter identifier values
  input  wire cef_ident_t [NUM_FILT-1:0]          filt_ident,
  // received message to filter
  input  wire logic                               msg_valid,
  input  wire cef_ident_t                         msg_ident,
  // status and acceptance result
  output cef_err_flags_t                          err_flags,
  output logic      [NUM_FIFO-1:0]                fifo_irq_pending,
  output logic                                    accept_valid,
  output logic      [$clog2(NUM_FIFO)-1:0]        accept_fifo,
  output logic      [$clog2(NUM_FILT)-1:0]        accept_filter
);

  localparam int FW = $clog2(NUM_FILT);
  localparam int MW = $clog2(NUM_MASK);
  localparam int QW = $clog2(NUM_FIFO);
  localparam int NREG = NUM_FILT / `CEF_FLT_PER_REG;

  // ----------------------------------------
  // state
  // ----------------------------------------
  cef_err_flags_t              flags_q;
  logic [7:0]                  tx_cnt_q;
  logic [7:0]                  rx_cnt_q;
  logic [NUM_FIFO-1:0]         pend_q;
  logic [NUM_MASK-1:0][31:0]   mask_q;
  cef_fltctl_t [NUM_FILT-1:0]  fctl_q;
  logic [31:0]                 prdata_q;
  logic                        slverr_q;
  logic                        acc_valid_q;
  logic [QW-1:0]               acc_fifo_q;
  logic [FW-1:0]               acc_filt_q;

  // ----------------------------------------
  // error state flags
  // ----------------------------------------
  logic tx_warn;
  logic rx_warn;

  // warning is a window below passive, so the upper bound is strict
  assign tx_warn = (tx_error_count >= `CEF_LVL_WARN)
                 && (tx_error_count < `CEF_LVL_PASSIVE);
  assign rx_warn = (rx_error_count >= `CEF_RLVL_WARN)
                 && (rx_error_count < `CEF_RLVL_PASSIVE);

  // flags and counts are sampled together so a read never tears
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags_q  <= '0;
      tx_cnt_q <= 8'h00;
      rx_cnt_q <= 8'h00;
    end else begin
      flags_q.tx_bus_off_flag  <= tx_error_count >= `CEF_LVL_BUSOFF;
      flags_q.tx_passive_flag  <= tx_error_count >= `CEF_LVL_PASSIVE;
      flags_q.rx_passive_flag  <= rx_error_count >= `CEF_RLVL_PASSIVE;
      flags_q.tx_warning_flag  <= tx_warn;
      flags_q.rx_warning_flag  <= rx_warn;
      flags_q.any_warning_flag <= tx_warn | rx_warn;
      tx_cnt_q <= tx_error_count[7:0];
      rx_cnt_q <= rx_error_count;
    end
  end

  assign err_flags = flags_q;

  // ----------------------------------------
  // fifo interrupt pending
  // ----------------------------------------
  // a source only counts when its own enable is set
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_q <= '0;
    end else begin
      for (int n = 0; n < NUM_FIFO; n++) begin
        pend_q[n] <= |(fifo_irq_src[n] & fifo_irq_en[n]);
      end
    end
  end

  assign fifo_irq_pending = pend_q;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic [9:0] idx;
  logic       setup;
  logic       wr_acc;
  logic       is_err;
  logic       is_fst;
  logic       is_msk;
  logic       is_flt;
  logic [9:0] msk_off;
  logic [9:0] flt_off;

  assign idx     = paddr[`CEF_ADDR_W-1:2];
  assign setup   = psel & ~penable;
  assign wr_acc  = psel & penable & pwrite;
  assign msk_off = idx - `CEF_IDX_MASK0;
  assign flt_off = idx - `CEF_IDX_FCTL0;
  assign is_err  = idx == `CEF_IDX_ERRCNT;
  assign is_fst  = idx == `CEF_IDX_FSTAT;
  assign is_msk  = (idx >= `CEF_IDX_MASK0) && (msk_off < 10'(NUM_MASK));
  assign is_flt  = (idx >= `CEF_IDX_FCTL0) && (flt_off < 10'(NREG));

  // ----------------------------------------
  // acceptance masks
  // ----------------------------------------
  // writes outside configuration mode are dropped, which keeps the
  // filter logic from seeing a half-updated mask mid-frame
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mask_q <= '0;
    end else if (wr_acc && is_msk
                 && (operating_mode_field == `CEF_OPERATING_MODE_FIELD_CFG)) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          mask_q[msk_off[MW-1:0]][b*8 +: 8] <=
            pwdata[b*8 +: 8] & 8'(`CEF_MSK_RW >> (b*8));
        end
      end
    end
  end

  // ----------------------------------------
  // filter control
  // ----------------------------------------
  // the enable bit is always writable; selects only follow a write
  // while the filter is currently disabled
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fctl_q <= '{default: `CEF_FLT_RST};
    end else if (wr_acc && is_flt) begin
      for (int k = 0; k < NUM_FILT; k++) begin
        if ((k / `CEF_FLT_PER_REG) == int'(flt_off)
            && pstrb[k % `CEF_FLT_PER_REG]) begin
          fctl_q[k].filter_enable <=
            pwdata[(k % `CEF_FLT_PER_REG)*8 + 7];
          if (!fctl_q[k].filter_enable) begin
            fctl_q[k].mask_select <=
              pwdata[(k % `CEF_FLT_PER_REG)*8 + 5 +: 2];
            fctl_q[k].fifo_select <=
              pwdata[(k % `CEF_FLT_PER_REG)*8 +: 5];
          end
        end
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_err) begin
      rd_word = 32'({flags_q, tx_cnt_q, rx_cnt_q});
    end else if (is_fst) begin
      rd_word = 32'(pend_q);
    end else if (is_msk) begin
      rd_word = mask_q[msk_off[MW-1:0]];
    end else if (is_flt) begin
      for (int k = 0; k < NUM_FILT; k++) begin
        if ((k / `CEF_FLT_PER_REG) == int'(flt_off)) begin
          rd_word[(k % `CEF_FLT_PER_REG)*8 +: 8] = fctl_q[k];
        end
      end
    end
  end

  // read data and error are captured in the setup phase so the
  // access phase can finish with zero wait states
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
      slverr_q <= ~(is_err | is_fst | is_msk | is_flt);
    end
  end

  assign prdata  = prdata_q;
  assign pready  = psel & penable;
  assign pslverr = psel & penable & slverr_q;

  // ----------------------------------------
  // acceptance filtering
  // ----------------------------------------
  logic          hit_any;
  logic [FW-1:0] hit_idx;
  logic [31:0]   m;
  logic          std_ok;
  logic          ext_ok;
  logic          hit;

  // scan from the top down so the lowest-numbered filter wins
  always_comb begin
    hit_any = 1'b0;
    hit_idx = '0;
    m       = 32'h0000_0000;
    std_ok  = 1'b0;
    ext_ok  = 1'b0;
    hit     = 1'b0;
    for (int k = NUM_FILT - 1; k >= 0; k--) begin
      m = mask_q[fctl_q[k].mask_select[MW-1:0]];
      std_ok = ((msg_ident.std_id ^ filt_ident[k].std_id)
               & m[`CEF_MSK_STD_HI:`CEF_MSK_STD_LO]) == '0;
      ext_ok = ((msg_ident.ext_id ^ filt_ident[k].ext_id)
               & m[`CEF_MSK_EXT_HI:`CEF_MSK_EXT_LO]) == '0;
      if (m[`CEF_MSK_TYPE]) begin
        hit = (msg_ident.ext == filt_ident[k].ext)
              && std_ok && (!msg_ident.ext || ext_ok);
      end else begin
        // a standard match alone suffices; the full match implies it
        hit = std_ok || (std_ok && ext_ok);
      end
      if (fctl_q[k].filter_enable && hit) begin
        hit_any = 1'b1;
        hit_idx = FW'(k);
      end
    end
  end

  // result is a one-cycle pulse per message, fifo taken from the
  // winning filter's select field
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_valid_q <= 1'b0;
      acc_fifo_q  <= '0;
      acc_filt_q  <= '0;
    end else begin
      acc_valid_q <= msg_valid & hit_any;
      if (msg_valid && hit_any) begin
        acc_fifo_q <= QW'(fctl_q[hit_idx].fifo_select);
        acc_filt_q <= hit_idx;
      end
    end
  end

  assign accept_valid  = acc_valid_q;
  assign accept_fifo   = acc_fifo_q;
  assign accept_filter = acc_filt_q;

endmodule

// ---- tb/cef_node_model.sv ----
`timescale 1ns/1ps
module cef_node_model
  import cef_pkg::*;
(
  // clock
  input  wire logic       core_clk,
  // frame request from the bench
  input  wire logic       send,
  input  wire cef_ident_t ident,
  // received frame toward the filter
  output logic            msg_valid,
  output cef_ident_t      msg_ident
);
  // id lines toggle between frames so a stale id can never pass for a new one
  always @(posedge core_clk) begin
    msg_valid <= send;
    msg_ident <= send ? ident : ~msg_ident;
  end
endmodule

// ---- tb/cef_props.sv ----
`timescale 1ns/1ps
module cef_props
  import cef_pkg::*;
#(
  parameter int NUM_FIFO = 32,
  parameter int IRQ_SRC  = 4
) (
  // clock and reset
  input wire logic                             core_clk,
  input wire logic                             rst,
  // engine side
  input wire logic [8:0]                       tx_error_count,
  input wire logic [7:0]                       rx_error_count,
  input wire logic [NUM_FIFO-1:0][IRQ_SRC-1:0] fifo_irq_src,
  input wire logic [NUM_FIFO-1:0][IRQ_SRC-1:0] fifo_irq_en,
  input wire logic                             msg_valid,
  // results
  input wire cef_err_flags_t                   err_flags,
  input wire logic [NUM_FIFO-1:0]              fifo_irq_pending,
  input wire logic                             accept_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [8:0]          tx_q;
  logic [7:0]          rx_q;
  logic [NUM_FIFO-1:0] want;
  // counts seen one edge ago, since the flags are registered
  always_ff @(posedge core_clk) begin
    tx_q <= tx_error_count;
    rx_q <= rx_error_count;
  end
  // pending expectation, one bit per fifo
  always_comb begin
    for (int i = 0; i < NUM_FIFO; i++) want[i] = |(fifo_irq_src[i] & fifo_irq_en[i]);
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_tx_busoff: assert property (!$past(rst) |->
    err_flags.tx_bus_off_flag == (tx_q >= 9'h100)) else $error("tx bus-off flag wrong");
  a_tx_passive: assert property (!$past(rst) |->
    err_flags.tx_passive_flag == (tx_q >= 9'h080)) else $error("tx passive flag wrong");
  a_rx_passive: assert property (!$past(rst) |->
    err_flags.rx_passive_flag == (rx_q >= 8'h80)) else $error("rx passive flag wrong");
  a_tx_warn: assert property (!$past(rst) |->
    err_flags.tx_warning_flag == (tx_q >= 9'h060 && tx_q < 9'h080))
    else $error("tx warning flag wrong");
  a_rx_warn: assert property (!$past(rst) |->
    err_flags.rx_warning_flag == (rx_q >= 8'h60 && rx_q < 8'h80))
    else $error("rx warning flag wrong");
  a_any_warn: assert property (!$past(rst) |->
    err_flags.any_warning_flag == ((tx_q >= 9'h060 && tx_q < 9'h080)
                                   || (rx_q >= 8'h60 && rx_q < 8'h80)))
    else $error("combined warning wrong");
  a_fifo_pend: assert property (!$past(rst) |->
    fifo_irq_pending == $past(want)) else $error("fifo pending wrong");
  a_accept_cause: assert property (accept_valid |-> $past(msg_valid))
    else $error("accept without message");
  c_accept: cover property (accept_valid);
  c_busoff: cover property (err_flags.tx_bus_off_flag);
  c_warn: cover property (err_flags.any_warning_flag);
endmodule

bind cef_top cef_props #(.NUM_FIFO(NUM_FIFO), .IRQ_SRC(IRQ_SRC)) u_cef_props (.*);

// ---- tb/cef_top_bench.sv ----
`timescale 1ns/1ps
module cef_top_bench
  import cef_pkg::*;
;
  logic                  core_clk = 1'b0;
  logic                  rst, psel, penable, pwrite, pready, pslverr, send;
  logic                  msg_valid, accept_valid, err_seen;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, rd, e;
  logic [3:0]            pstrb;
  logic [8:0]            tx_error_count;
  logic [7:0]            rx_error_count;
  logic [2:0]            operating_mode_field;
  logic [31:0][3:0]      fifo_irq_src, fifo_irq_en;
  cef_ident_t [31:0]     filt_ident;
  cef_ident_t            ident, msg_ident;
  cef_err_flags_t        err_flags;
  logic [31:0]           fifo_irq_pending;
  logic [4:0]            accept_fifo, accept_filter;
  int                    err_total = 0;
  int                    n_compared = 0;

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  cef_top u_cef_top (.*);
  cef_node_model u_cef_node_model (.core_clk(core_clk), .send(send), .ident(ident),
    .msg_valid(msg_valid), .msg_ident(msg_ident));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask

  // one apb transfer; waits for pready, never assumes a latency
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) begin
      err_total++;
      tally_and_finish();
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task send_msg(input cef_ident_t id, input logic acc, input logic [4:0] f);
    @(posedge core_clk);
    send <= 1'b1; ident <= id;
    @(posedge core_clk);
    send <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(accept_valid, acc);
    if (acc) chk(accept_fifo, f);
    if (acc) chk(accept_filter, 32'd5);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_err();
    int tv[7] = '{0, 95, 96, 127, 128, 255, 256};
    int rv[7] = '{127, 128, 96, 95, 255, 0, 96};
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk);
      tx_error_count <= 9'(tv[i]); rx_error_count <= 8'(rv[i]);
      e = {10'h0, tv[i] >= 256, tv[i] >= 128, rv[i] >= 128, tv[i] >= 96 && tv[i] < 128,
           rv[i] >= 96 && rv[i] < 128, (tv[i] >= 96 && tv[i] < 128) || (rv[i] >= 96 && rv[i] < 128),
           8'(tv[i]), 8'(rv[i])};
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, e);
    end
    apb(1'b1, 12'h000, 32'hffff_ffff);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, e);
    $display("error state test done");
  endtask

  task t_pend();
    for (int i = 0; i < 32; i++) begin
      fifo_irq_src[i] <= 4'(i);
      fifo_irq_en[i] <= (i < 16) ? 4'h5 : 4'ha;
      e[i] = |(4'(i) & ((i < 16) ? 4'h5 : 4'ha));
    end
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, e);
    chk(err_seen, 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk(err_seen, 1'b1);
    chk(rd, 32'h0);
    $display("pending test done");
  endtask

  task t_filt();
    operating_mode_field <= 3'h4;
    apb(1'b1, 12'h014, 32'hffe0_0000);
    apb(1'b1, 12'h018, 32'hffe8_0000);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'hffeb_ffff);
    operating_mode_field <= 3'h0;
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'hffeb_ffff);
    apb(1'b1, 12'h024, 32'h0000_b100);
    send_msg({11'h123, 1'b1, 18'h2a5a5}, 1'b1, 5'd17);
    send_msg({11'h124, 1'b0, 18'h0}, 1'b0, 5'd0);
    // enable is dropped but the select fields must survive, it was set
    apb(1'b1, 12'h024, 32'h0000_0300);
    apb(1'b0, 12'h024, 32'h0);
    chk(rd, 32'h0000_3100);
    send_msg({11'h123, 1'b0, 18'h0}, 1'b0, 5'd0);
    apb(1'b1, 12'h024, 32'h0000_df00);
    send_msg({11'h123, 1'b1, 18'h0}, 1'b0, 5'd0);
    send_msg({11'h123, 1'b0, 18'h3ffff}, 1'b1, 5'd31);
    $display("filter test done");
  endtask

  task tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    pstrb = 4'hf; send = 1'b0; ident = '0; tx_error_count = '0; rx_error_count = '0;
    operating_mode_field = 3'h0; fifo_irq_src = '0; fifo_irq_en = '0; filt_ident = '0;
    filt_ident[5] = {11'h123, 1'b0, 18'h0};
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_err();
    t_pend();
    t_filt();
    tally_and_finish();
  end

  // watchdog well beyond the hundred or so cycles the scenarios need
  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end
endmodule
